// ### rtl/oei_defs.vh
`ifndef OEI_DEFS_VH
`define OEI_DEFS_VH

// Register byte addresses on the APB window.
`define OEI_ADDR_FLAGS    8'h00
`define OEI_ADDR_MASK     8'h04
`define OEI_ADDR_CTRL     8'h08
`define OEI_ADDR_LEVELS   8'h0C

// Event flag positions.
`define OEI_BIT_ID        7
`define OEI_BIT_MS        6
`define OEI_BIT_LINE      5
`define OEI_BIT_ACTV      4
`define OEI_BIT_SESSLVL   3
`define OEI_BIT_BVBUS     2
`define OEI_BIT_AVBUS     0

// Bits that exist in the flag and mask registers.
`define OEI_FLAG_IMPL     8'hFD
`define OEI_FLAG_RESET    8'h00

// Control register fields.
`define OEI_CTRL_TMR_EN   0
`define OEI_CTRL_SLEEP    1
`define OEI_CTRL_W        2
`define OEI_CTRL_RESET    2'h0

// Timing: one millisecond at an 8 ns clock.
`define OEI_MS_NS         1000000
`define OEI_CLK_NS        8

`endif

// ### rtl/oei_sync.v
`timescale 1ns/1ps
module oei_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             clk_i,
  input  wire             arst_n_i,
  // Asynchronous levels in, settled levels out.
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] level_o,
  output reg              valid_o
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // A new level is only accepted when the second and third stages agree,
  // which filters a sample caught mid-transition. The first cycle after
  // reset accepts the zeroed stages and raises valid_o, so a pin already high is later reported as a change.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q    <= {WIDTH{1'b0}};
      s2_q    <= {WIDTH{1'b0}};
      s3_q    <= {WIDTH{1'b0}};
      level_o <= {WIDTH{1'b0}};
      valid_o <= 1'b0;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        level_o <= s3_q;
        valid_o <= 1'b1;
      end
    end
  end

endmodule // oei_sync

// ### rtl/oei_interval.v
`timescale 1ns/1ps
module oei_interval #(
  parameter CYCLES = 125000
) (
  // Clock and reset.
  input  wire clk_i,
  input  wire arst_n_i,
  // Control.
  input  wire en_i,
  input  wire restart_i,
  // One-cycle pulse each time CYCLES enabled cycles have passed.
  output reg  done_o
);

  function integer clog2f;
    input integer v;
    integer       n;
    begin
      n = 0;
      while ((1 << n) < v)
        n = n + 1;
      clog2f = (n < 1) ? 1 : n;
    end
  endfunction

  localparam CW = clog2f(CYCLES);
  localparam [CW-1:0] LAST = CYCLES - 1;

  reg [CW-1:0] cnt_q;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q  <= {CW{1'b0}};
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (restart_i || !en_i)
        cnt_q <= {CW{1'b0}};
      else if (cnt_q == LAST)
      begin
        cnt_q  <= {CW{1'b0}};
        done_o <= 1'b1;
      end
      else
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule // oei_interval

// ### rtl/oei_otg_flags.v
// Overview of operation
// - ID pin change sets bit 7.
// - One millisecond timer expiry sets bit 6.
// - Line stable 1 ms and new sets bit 5.
// - Pin activity waking device sets bit 4.
// - VBUS falling below session end (session end input rising) sets bit 3.
// - Any session end input change sets bit 2.
// - Any session valid input change sets bit 0.
// - Hardware sets flags; writing one clears.
// - Bits 31 to 8 and 1 read zero.
`timescale 1ns/1ps
`include "oei_defs.vh"
module oei_otg_flags #(
  parameter MS_CYCLES = (`OEI_MS_NS + `OEI_CLK_NS - 1) / `OEI_CLK_NS
) (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        arst_n_i,
  // APB slave.
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Cable side levels and comparators.
  input  wire        dp_i,
  input  wire        dm_i,
  input  wire        id_i,
  input  wire        vbus_i,
  input  wire        sess_end_i,
  input  wire        sess_vld_i,
  // Interrupt and wake.
  output wire        irq_o,
  output wire        asleep_o
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  wire [5:0] pins_s;
  wire       pins_ok;

  oei_sync #(
    .WIDTH    (6)
  ) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({sess_vld_i, sess_end_i, vbus_i, id_i, dm_i, dp_i}),
    .level_o  (pins_s),
    .valid_o  (pins_ok)
  );

  reg  [5:0] pins_q;
  reg        primed_q;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pins_q   <= 6'h00;
      primed_q <= 1'b0;
    end
    else if (pins_ok)
    begin
      pins_q   <= pins_s;
      primed_q <= 1'b1;
    end
  end

  // Edges are reported only once a reference level has been captured.
  wire [5:0] pin_chg = primed_q ? (pins_s ^ pins_q) : 6'h00;

  wire [1:0] line_s   = pins_s[1:0];
  wire       id_chg   = pin_chg[2];
  wire       vb_chg   = pin_chg[3];
  wire       se_chg   = pin_chg[4];
  wire       sv_chg   = pin_chg[5];
  wire       se_rise  = se_chg & pins_s[4];

  //////////////////////////////////////////////////////////////////////////
  // Control register and timers.

  reg  [`OEI_CTRL_W-1:0] ctrl_q;
  wire                   tmr_en = ctrl_q[`OEI_CTRL_TMR_EN];
  wire                   sleep  = ctrl_q[`OEI_CTRL_SLEEP];
  wire                   ms_done;
  wire                   line_done;

  oei_interval #(
    .CYCLES    (MS_CYCLES)
  ) u_ms_timer (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .en_i      (tmr_en),
    .restart_i (1'b0),
    .done_o    (ms_done)
  );

  // The stability window restarts on every change of D+ or D-.
  oei_interval #(
    .CYCLES    (MS_CYCLES)
  ) u_line_timer (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .en_i      (primed_q),
    .restart_i (|pin_chg[1:0]),
    .done_o    (line_done)
  );

  reg  [1:0] line_stable_q;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      line_stable_q <= 2'h0;
    else if (line_done)
      line_stable_q <= line_s;
  end

  wire line_new = line_done & (line_s != line_stable_q);

  //////////////////////////////////////////////////////////////////////////
  // APB access decode.

  // One wait state: the access phase is answered on its second cycle so
  // that read data and the error reply come straight from flip-flops.
  wire acc     = psel_i & penable_i;
  wire commit  = acc & pready_o;
  wire wr      = commit & pwrite_i;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OEI_ADDR_FLAGS) || (a == `OEI_ADDR_MASK) ||
               (a == `OEI_ADDR_CTRL)  || (a == `OEI_ADDR_LEVELS);
    end
  endfunction

  wire wr_flags = wr & (paddr_i == `OEI_ADDR_FLAGS);
  wire wr_mask  = wr & (paddr_i == `OEI_ADDR_MASK);
  wire wr_ctrl  = wr & (paddr_i == `OEI_ADDR_CTRL);

  //////////////////////////////////////////////////////////////////////////
  // Event flags.

  reg  [7:0] flags_q;
  reg  [7:0] flags_d;
  reg  [7:0] mask_q;
  reg  [7:0] set_v;
  reg  [7:0] clr_v;
  wire       wake = sleep & (|pin_chg[3:0]);

  always @*
  begin
    set_v = 8'h00;
    set_v[`OEI_BIT_ID]      = id_chg;
    set_v[`OEI_BIT_MS]      = ms_done;
    set_v[`OEI_BIT_LINE]    = line_new;
    set_v[`OEI_BIT_ACTV]    = wake;
    set_v[`OEI_BIT_SESSLVL] = se_rise;
    set_v[`OEI_BIT_BVBUS]   = se_chg;
    set_v[`OEI_BIT_AVBUS]   = sv_chg;
    // Only ones in the write data clear; zeros leave flags alone.
    clr_v = wr_flags ? pwdata_i[7:0] : 8'h00;
    // A set in the clearing cycle survives the clear.
    flags_d = ((flags_q & ~clr_v) | set_v)
              & `OEI_FLAG_IMPL;
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flags_q <= `OEI_FLAG_RESET;
      mask_q  <= `OEI_FLAG_RESET;
      ctrl_q  <= `OEI_CTRL_RESET;
    end
    else
    begin
      flags_q <= flags_d;
      if (wr_mask)
        mask_q <= pwdata_i[7:0] & `OEI_FLAG_IMPL;
      if (wr_ctrl)
        ctrl_q <= pwdata_i[`OEI_CTRL_W-1:0];
      else if (wake)
        // Activity ends sleep; the flag records why.
        ctrl_q[`OEI_CTRL_SLEEP] <= 1'b0;
    end
  end

  assign irq_o    = |(flags_q & mask_q);
  assign asleep_o = sleep;

  //////////////////////////////////////////////////////////////////////////
  // Read mux and APB reply.

  reg [31:0] rd_v;

  always @*
  begin
    rd_v = 32'h0000_0000;
    case (paddr_i)
      `OEI_ADDR_FLAGS:  rd_v[7:0] = flags_q;
      `OEI_ADDR_MASK:   rd_v[7:0] = mask_q;
      `OEI_ADDR_CTRL:   rd_v[`OEI_CTRL_W-1:0] = ctrl_q;
      `OEI_ADDR_LEVELS: rd_v[7:0] = {line_stable_q, pins_s};
      default:          rd_v = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (acc && !pready_o)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= ~mapped(paddr_i);
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_v;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
  end

endmodule // oei_otg_flags

// ### verif/oei_otg_flags_chk.sv
`timescale 1ns/1ps
module oei_otg_flags_chk (
  // Clock, reset and bus.
  input wire        clk_i,
  input wire        arst_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  // Pins and interrupt.
  input wire        id_i,
  input wire        sess_end_i,
  input wire        sess_vld_i,
  input wire        irq_o
);
  reg  [7:0] m_q;
  wire       wr0 = pready_o && pwrite_i && paddr_i == 8'h00;
  wire       rd0 = pready_o && !pwrite_i && paddr_i == 8'h00;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // The mask shadow changes at the edge that completes the write.
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      m_q <= 8'h00;
    else if (pready_o && pwrite_i && paddr_i == 8'h04)
      m_q <= pwdata_i[7:0] & 8'hFD;
  ack_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered");
  ack_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  flag_pad_a: assert property (rd0 |-> prdata_o[31:8] == 24'h0 && !prdata_o[1])
    else $error("unused flag bit set");
  id_irq_a: assert property (m_q[7] && $changed(id_i) |-> ##[1:10] irq_o)
    else $error("id change lost");
  sv_irq_a: assert property (m_q[0] && $changed(sess_vld_i) |-> ##[1:10] irq_o)
    else $error("session valid change lost");
  se_irq_a: assert property (m_q[2] && $changed(sess_end_i) |-> ##[1:10] irq_o)
    else $error("session end change lost");
  zero_keep_a: assert property (wr0 && pwdata_i[7:0] == 8'h00 && irq_o |=> irq_o)
    else $error("zero write cleared a flag");
  mask_gate_a: assert property (m_q == 8'h00 |-> !irq_o)
    else $error("masked interrupt raised");
  cover property (wr0 && irq_o);
  cover property ($rose(irq_o));
  cover property (rd0 && prdata_o[6]);
endmodule // oei_otg_flags_chk
////////////////////////////////////////////////////////////
bind oei_otg_flags oei_otg_flags_chk oei_otg_flags_chk_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .id_i(id_i), .sess_end_i(sess_end_i), .sess_vld_i(sess_vld_i),
  .irq_o(irq_o));

// ### verif/oei_cable.sv
`timescale 1ns/1ps
module oei_cable (
  // Clock and commanded levels.
  input  wire       clk_i,
  input  wire [5:0] lvl_i,
  input  wire       slow_i,
  // Levels {sess_vld, sess_end, vbus, id, dm, dp}.
  output reg  [5:0] pin_o
);
  reg [5:0] dly_q = 6'h00;
  initial pin_o = 6'h00;
  // A slow cable settles a cycle late, like a long lead charging up.
  always @(posedge clk_i)
  begin
    dly_q <= lvl_i;
    pin_o <= slow_i ? dly_q : lvl_i;
  end
endmodule // oei_cable

// ### verif/test_otg_interrupt_status.sv
`timescale 1ns/1ps
module test_otg_interrupt_status;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  lvl = 6'h00;
  logic        slow = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [5:0]  pin;
  wire         irq;
  wire         asleep;
  logic [31:0] rd;
  logic        er;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [5:0]  lv [6] = '{6'h04, 6'h24, 6'h34, 6'h24, 6'h2C, 6'h08};
  logic [31:0] ex [6] = '{32'h80, 32'h01, 32'h0C, 32'h04, 32'h00, 32'h81};
  oei_otg_flags #(.MS_CYCLES(20)) oei_otg_flags_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .dp_i(pin[0]), .dm_i(pin[1]), .id_i(pin[2]),
    .vbus_i(pin[3]), .sess_end_i(pin[4]), .sess_vld_i(pin[5]),
    .irq_o(irq), .asleep_o(asleep));
  oei_cable oei_cable_inst (.clk_i(clk_i), .lvl_i(lvl), .slow_i(slow),
    .pin_o(pin));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Read data is taken at the same edge that samples pready high.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 9)
    begin
      @(posedge clk_i);
      n++;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task pins(input logic [5:0] v);
    @(posedge clk_i) lvl <= v;
    wt(12);
  endtask
  task results;
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    bus(1'b1, 8'h04, 32'hFFFF_FFFF);
    rdc(8'h04, 32'hFD);
    for (int i = 0; i < 6; i++)
    begin
      pins(lv[i]);
      rdc(8'h00, ex[i]);
      chk({31'h0, irq}, {31'h0, ex[i] != 32'h0});
      bus(1'b1, 8'h00, 32'hFFFF_FFFF);
      rdc(8'h00, 32'h0);
    end
    pins(6'h0C);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'hFFFF_FF7F);
    rdc(8'h00, 32'h80);
    bus(1'b1, 8'h00, 32'h80);
    bus(1'b1, 8'h08, 32'h1);
    wt(30);
    bus(1'b1, 8'h08, 32'h0);
    rdc(8'h00, 32'h40);
    bus(1'b1, 8'h00, 32'h40);
    slow <= 1'b1;
    pins(6'h0D);
    wt(28);
    rdc(8'h00, 32'h20);
    bus(1'b1, 8'h00, 32'h20);
    wt(40);
    rdc(8'h00, 32'h0);
    bus(1'b1, 8'h08, 32'h2);
    wt(1);
    chk({31'h0, asleep}, 32'h1);
    pins(6'h05);
    chk({31'h0, asleep}, 32'h0);
    rdc(8'h00, 32'h10);
    bus(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'h10);
    pins(6'h01);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h00, 32'h80);
    rdc(8'h0C, 32'h41);
    @(posedge clk_i) arst_n_i <= 1'b0;
    wt(3);
    @(posedge clk_i) arst_n_i <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h0);
    results();
  end
endmodule // test_otg_interrupt_status
